/* common/tdxext_pkg.sv */
package tdxext_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_BRK_SRC = 8'h90;
  localparam logic [7:0] ADDR_WDG_PERIOD = 8'h94;
  localparam logic [7:0] ADDR_REPEAT_SECOND = 8'h98;
  localparam logic [7:0] ADDR_DEADTIME_SECOND = 8'h9c;
  localparam logic [7:0] ADDR_DECODER_INDEX = 8'ha0;
  localparam logic [7:0] ADDR_PRELOAD_CTRL = 8'ha4;
  localparam logic [7:0] ADDR_PRELOAD_VALUE = 8'ha8;
  localparam logic [7:0] ADDR_CONFIG = 8'hac;
  localparam logic [7:0] ADDR_STATUS = 8'hb0;
  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [31:0] RST_WDG_PERIOD = 32'hffffffff;
  localparam logic [31:0] RST_ZERO = 32'h00000000;
  localparam logic [31:0] MASK_BRK_SRC = 32'h0000ff87;
  localparam logic [31:0] MASK_DEADTIME = 32'h000300ff;
  localparam logic [31:0] MASK_DECODER = 32'h07ff00e7;
  localparam logic [31:0] MASK_PRELOAD_CTRL = 32'h00000003;
  localparam logic [31:0] MASK_PRELOAD_VALUE = 32'h0000ffff;
  localparam logic [31:0] MASK_CONFIG = 32'h0000003f;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_DT_LIVE = 17;
  localparam int BIT_DT_ASYM = 16;
  localparam int BIT_FIRST_INDEX = 5;
  localparam int BIT_INDEX_EN = 0;
  localparam int BIT_SOFT_SYNC = 2;
  localparam int BIT_PRELOAD_DIR = 1;
  localparam int BIT_PRELOAD_EN = 0;
  localparam int BIT_CFG_REPSEL = 0;
  localparam int BIT_CFG_DDEN = 1;
  localparam int BIT_CFG_DDIE = 2;
  localparam logic [1:0] PROTECTION_LEVEL_OPEN = 2'h0;
  localparam logic [1:0] DIR_BOTH = 2'h0;
  localparam logic [1:0] DIR_UP = 2'h1;
  localparam logic [1:0] DIR_DOWN = 2'h2;
  localparam logic [2:0] DECODER_MODE_AB_MAX = 3'h4;
  localparam logic [2:0] DECODER_MODE_CLK_MAX = 3'h3;
  typedef enum logic [1:0] {PULSE_IDLE, PULSE_HIGH} tdxext_pulse_e;
endpackage

/* logic/tdxext_top.sv */
`timescale 1ns/10ps
// Notes on behaviour
// [R1] Comparator gate bits 9..15 and 7 pass comparators 0..6 and 7 into second break.
// [R2] Bit 8 gates the filter-unit break into second break.
// [R3] Bits 2:0 gate break pins 0..2 into second break.
// [R4] Break gates and dead-time bits write only while protection level is 00.
// [R5] Watchdogs time out at period; set disconnect flag, interrupt if enabled.
// [R6] Period used only with disconnect detection enabled.
// [R7] Second repeat value readable; update each time repeat counter hits zero.
// [R8] Second repeat value used only when select bit is 1.
// [R9] Live dead-time update: writes after last update ignored while running.
// [R10] Asymmetric bit picks falling dead time from second register; here DEADTIME_FALL holds its last value instead.
// [R11] Dead-time code decoded into tDTS units by top three bits.
// [R12] Pulse clock is 2^prescale cycles; pulse lasts width of those.
// [R13] Mode 4: index position picks AB state for counter reset.
// [R14] Modes 0..3: low position bit picks clock level for reset.
// [R15] First-index bit limits reset to the first index only.
// [R16] Direction field: both, up only, down only, reserved.
// [R17] Software changes direction only while index reset is disabled.
// [R18] Index reset enable bit gates every index reset.
// [R19] Soft sync bit pulses a sync event, self clears, reads zero.
// [R20] After sync load, direction comes from preload direction in center modes.
// [R21] Preload enable lets sync events load the 16-bit preload value.
// [R22] Software uses full 32-bit word accesses only.
// [R23] Reserved bits read zero; writes to them ignored.
module tdxext_top
  import tdxext_pkg::*;
#(
  parameter int REP_W = 32
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Timer core context
  input wire logic [1:0] PROTECTION_LEVEL,
  input wire logic COUNTER_ENABLE,
  input wire logic UPDATE_EVENT,
  input wire logic COUNT_TICK,
  input wire logic [1:0] CENTER_ALIGN_MODE,
  input wire logic COUNT_DOWN,
  input wire logic [2:0] DECODER_MODE,
  input wire logic HW_SYNC,
  // Break sources
  input wire logic [7:0] BRK_B_COMPARATOR,
  input wire logic BRK_B_FILTER_UNIT,
  input wire logic [2:0] BRK_B_PIN,
  // Encoder signals
  input wire logic ENC_A,
  input wire logic ENC_B,
  input wire logic ENC_INDEX,
  input wire logic ENC_A_EDGE,
  input wire logic ENC_B_EDGE,
  // Results to the core
  output logic BRK_B_OUT,
  output logic [7:0] DEADTIME_RISE,
  output logic [7:0] DEADTIME_FALL,
  output logic [11:0] DEADTIME_RISE_TICKS,
  output logic [11:0] DEADTIME_FALL_TICKS,
  output logic REPEAT_UPDATE,
  output logic INDEX_RESET,
  output logic INDEX_PULSE,
  output logic PRELOAD_LOAD,
  output logic [15:0] PRELOAD_VALUE_OUT,
  output logic PRELOAD_DIR_UP,
  output logic DISCONNECT_FLAG,
  output logic DISCONNECT_IRQ
);

  // ****************************************
  // Functions
  // ****************************************
  // Dead-time code to ticks of tDTS
  function automatic logic [11:0] dt_ticks(input logic [7:0] code);
    logic [11:0] t;
    t = 12'h000;
    if (!code[7]) t = {4'h0, code}; // [R11]
    else if (!code[6]) t = {5'h00, 1'b1, code[5:0]} << 1; // [R11]
    else if (!code[5]) t = {6'h00, 1'b1, code[4:0]} << 3; // [R11]
    else t = {6'h00, 1'b1, code[4:0]} << 4; // [R11]
    return t;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] mask);
    return (old & ~mask) | (wd & mask); // [R23]
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] brk_src;
  logic [31:0] wdg_period;
  logic [REP_W-1:0] repeat_value_second;
  logic [31:0] deadtime_reg;
  logic [31:0] decoder_reg;
  logic [31:0] preload_ctrl;
  logic [31:0] preload_value;
  logic [31:0] config_reg;
  logic soft_sync_trigger;
  logic dt_written_since_update;
  logic [REP_W-1:0] rep_count;
  logic [31:0] wdg_cnt_a;
  logic [31:0] wdg_cnt_b;
  logic first_index_seen;
  logic [6:0] pre_cnt;
  logic [7:0] width_cnt;
  tdxext_pulse_e pulse_state;

  wire wr = PSEL && PENABLE && PWRITE;
  wire protection_level_open = (PROTECTION_LEVEL == PROTECTION_LEVEL_OPEN);
  wire dt_locked = deadtime_reg[BIT_DT_LIVE] && COUNTER_ENABLE && dt_written_since_update;
  wire repsel = config_reg[BIT_CFG_REPSEL];
  wire dd_en = config_reg[BIT_CFG_DDEN];
  wire sync_event = HW_SYNC || soft_sync_trigger;

  // Register writes, APB access at the access phase
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      brk_src <= RST_ZERO;
      wdg_period <= RST_WDG_PERIOD;
      repeat_value_second <= '0;
      deadtime_reg <= RST_ZERO;
      decoder_reg <= RST_ZERO;
      preload_ctrl <= RST_ZERO;
      preload_value <= RST_ZERO;
      config_reg <= RST_ZERO;
    end else if (wr) begin
      case (PADDR)
        ADDR_BRK_SRC: begin
          if (protection_level_open) brk_src <= merge(brk_src, PWDATA, MASK_BRK_SRC); // [R4]
        end
        ADDR_WDG_PERIOD: wdg_period <= PWDATA;
        ADDR_REPEAT_SECOND: repeat_value_second <= PWDATA[REP_W-1:0]; // [R7]
        ADDR_DEADTIME_SECOND: begin
          if (protection_level_open) deadtime_reg <= merge(deadtime_reg, PWDATA, MASK_DEADTIME); // [R4]
        end
        ADDR_DECODER_INDEX: begin
          // Direction field frozen while index reset is on
          if (decoder_reg[BIT_INDEX_EN]) begin
            decoder_reg <= merge(decoder_reg, PWDATA, MASK_DECODER & ~32'h00000006); // [R17]
          end else begin
            decoder_reg <= merge(decoder_reg, PWDATA, MASK_DECODER);
          end
        end
        ADDR_PRELOAD_CTRL: preload_ctrl <= merge(preload_ctrl, PWDATA, MASK_PRELOAD_CTRL);
        ADDR_PRELOAD_VALUE: preload_value <= merge(preload_value, PWDATA, MASK_PRELOAD_VALUE);
        ADDR_CONFIG: config_reg <= merge(config_reg, PWDATA, MASK_CONFIG);
        default: ;
      endcase
    end
  end

  // Soft sync is a one-cycle strobe; never stored as a readable bit
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) soft_sync_trigger <= 1'b0;
    else soft_sync_trigger <= wr && (PADDR == ADDR_PRELOAD_CTRL) && PWDATA[BIT_SOFT_SYNC]; // [R19]
  end

  // APB read data and ready; zero wait states
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= RST_ZERO;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      PRDATA <= RST_ZERO;
      if (PSEL && !PENABLE && !PWRITE) begin
        case (PADDR)
          ADDR_BRK_SRC: PRDATA <= brk_src;
          ADDR_WDG_PERIOD: PRDATA <= wdg_period;
          ADDR_REPEAT_SECOND: PRDATA <= 32'(repeat_value_second); // [R7]
          ADDR_DEADTIME_SECOND: PRDATA <= deadtime_reg;
          ADDR_DECODER_INDEX: PRDATA <= decoder_reg;
          ADDR_PRELOAD_CTRL: PRDATA <= preload_ctrl; // [R19]
          ADDR_PRELOAD_VALUE: PRDATA <= preload_value;
          ADDR_CONFIG: PRDATA <= config_reg;
          ADDR_STATUS: PRDATA <= {31'h0, DISCONNECT_FLAG};
          default: PRDATA <= RST_ZERO;
        endcase
      end
    end
  end

  // ****************************************
  // Second break path
  // ****************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) BRK_B_OUT <= 1'b0;
    else BRK_B_OUT <= |(BRK_B_COMPARATOR & {brk_src[7], brk_src[15:9]}) || // [R1]
                      |(BRK_B_PIN & brk_src[2:0]) || (BRK_B_FILTER_UNIT && brk_src[8]); // [R2] [R3]
  end

  // ****************************************
  // Dead time
  // ****************************************
  // Track writes since last update so live mode can hold them back until the next update
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) dt_written_since_update <= 1'b0;
    else if (UPDATE_EVENT) dt_written_since_update <= 1'b0;
    else if (wr && PADDR == ADDR_DEADTIME_SECOND && protection_level_open) dt_written_since_update <= 1'b1;
  end

  // Active dead-time values; held while writes are invalidated
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      DEADTIME_RISE <= 8'h00;
      DEADTIME_FALL <= 8'h00;
      DEADTIME_RISE_TICKS <= 12'h000;
      DEADTIME_FALL_TICKS <= 12'h000;
    end else begin
      if (!dt_locked) begin // [R9]
        DEADTIME_RISE <= deadtime_reg[7:0];
        DEADTIME_RISE_TICKS <= dt_ticks(deadtime_reg[7:0]); // [R11]
        // Second field of the falling edge lives outside; asymmetric keeps it separate
        DEADTIME_FALL <= deadtime_reg[BIT_DT_ASYM] ? DEADTIME_FALL : deadtime_reg[7:0]; // [R10]
        DEADTIME_FALL_TICKS <= deadtime_reg[BIT_DT_ASYM] ?
                               DEADTIME_FALL_TICKS : dt_ticks(deadtime_reg[7:0]); // [R10]
      end
    end
  end

  // ****************************************
  // Second repetition counter
  // ****************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rep_count <= '0;
      REPEAT_UPDATE <= 1'b0;
    end else begin
      REPEAT_UPDATE <= 1'b0;
      if (repsel && COUNT_TICK) begin // [R8]
        if (rep_count == '0) begin
          REPEAT_UPDATE <= 1'b1; // [R7]
          rep_count <= repeat_value_second;
        end else begin
          rep_count <= rep_count - 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Disconnection watchdogs
  // ****************************************
  // One watchdog each for encoder lines A and B; an edge restarts it
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wdg_cnt_a <= 32'h0;
      wdg_cnt_b <= 32'h0;
    end else if (!dd_en) begin // [R6]
      wdg_cnt_a <= 32'h0;
      wdg_cnt_b <= 32'h0;
    end else begin
      wdg_cnt_a <= (ENC_A_EDGE || wdg_cnt_a == wdg_period) ? 32'h0 : wdg_cnt_a + 1'b1;
      wdg_cnt_b <= (ENC_B_EDGE || wdg_cnt_b == wdg_period) ? 32'h0 : wdg_cnt_b + 1'b1;
    end
  end

  // Flag set beats a clear written in the same cycle
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      DISCONNECT_FLAG <= 1'b0;
      DISCONNECT_IRQ <= 1'b0;
    end else begin
      if (dd_en && ((wdg_cnt_a == wdg_period && !ENC_A_EDGE) ||
                    (wdg_cnt_b == wdg_period && !ENC_B_EDGE))) DISCONNECT_FLAG <= 1'b1; // [R5]
      else if (wr && PADDR == ADDR_STATUS && PWDATA[0]) DISCONNECT_FLAG <= 1'b0;
      DISCONNECT_IRQ <= DISCONNECT_FLAG && config_reg[BIT_CFG_DDIE]; // [R5]
    end
  end

  // ****************************************
  // Index reset
  // ****************************************
  logic idx_pos_ok;
  logic idx_dir_ok;
  always_comb begin
    idx_pos_ok = 1'b1;
    if (DECODER_MODE <= DECODER_MODE_CLK_MAX) idx_pos_ok = (ENC_A == decoder_reg[6]); // [R14]
    else if (DECODER_MODE <= DECODER_MODE_AB_MAX)
      idx_pos_ok = ({ENC_A, ENC_B} == decoder_reg[7:6]); // [R13]
    case (decoder_reg[2:1])
      DIR_BOTH: idx_dir_ok = 1'b1; // [R16]
      DIR_UP: idx_dir_ok = !COUNT_DOWN;
      DIR_DOWN: idx_dir_ok = COUNT_DOWN;
      default: idx_dir_ok = 1'b0;
    endcase
  end

  wire idx_hit = ENC_INDEX && decoder_reg[BIT_INDEX_EN] && idx_pos_ok && idx_dir_ok && // [R18]
                 !(decoder_reg[BIT_FIRST_INDEX] && first_index_seen); // [R15]

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      first_index_seen <= 1'b0;
      INDEX_RESET <= 1'b0;
    end else begin
      INDEX_RESET <= idx_hit;
      if (!decoder_reg[BIT_INDEX_EN]) first_index_seen <= 1'b0;
      else if (idx_hit) first_index_seen <= 1'b1; // [R15]
    end
  end

  // Output pulse generator: prescaled clock, width in those ticks
  wire pre_tick = (pre_cnt == 7'((1 << decoder_reg[26:24]) - 1)); // [R12]
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pre_cnt <= 7'h00;
      width_cnt <= 8'h00;
      pulse_state <= PULSE_IDLE;
      INDEX_PULSE <= 1'b0;
    end else begin
      pre_cnt <= pre_tick ? 7'h00 : pre_cnt + 1'b1;
      case (pulse_state)
        PULSE_IDLE: begin
          if (idx_hit && decoder_reg[23:16] != 8'h00) begin
            pulse_state <= PULSE_HIGH;
            width_cnt <= decoder_reg[23:16];
            pre_cnt <= 7'h00;
            INDEX_PULSE <= 1'b1;
          end
        end
        PULSE_HIGH: begin
          if (pre_tick) begin
            if (width_cnt == 8'h01) begin // [R12]
              pulse_state <= PULSE_IDLE;
              INDEX_PULSE <= 1'b0;
            end
            width_cnt <= width_cnt - 1'b1;
          end
        end
        default: pulse_state <= PULSE_IDLE;
      endcase
    end
  end

  // ****************************************
  // Counter preload on sync
  // ****************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PRELOAD_LOAD <= 1'b0;
      PRELOAD_VALUE_OUT <= 16'h0000;
      PRELOAD_DIR_UP <= 1'b0;
    end else begin
      PRELOAD_LOAD <= sync_event && preload_ctrl[BIT_PRELOAD_EN]; // [R21]
      PRELOAD_VALUE_OUT <= preload_value[15:0]; // [R21]
      // Direction only matters in center-aligned modes
      PRELOAD_DIR_UP <= (CENTER_ALIGN_MODE != 2'h0) ? preload_ctrl[BIT_PRELOAD_DIR] : 1'b1; // [R20]
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_protection_level_blocks_write: assert property (@(posedge CORE_CLK) disable iff (RST)
    wr && PADDR == ADDR_BRK_SRC && !protection_level_open |=> $stable(brk_src)) // [R4]
    else $error("break gates changed under protection");
  a_soft_sync_load: assert property (@(posedge CORE_CLK) disable iff (RST)
    wr && PADDR == ADDR_PRELOAD_CTRL && PWDATA[BIT_SOFT_SYNC] && PWDATA[BIT_PRELOAD_EN] |=>
      ##1 PRELOAD_LOAD) // [R19]
    else $error("soft sync did not load");
  a_no_load_disabled: assert property (@(posedge CORE_CLK) disable iff (RST)
    !preload_ctrl[0] && $stable(preload_ctrl) |=> !PRELOAD_LOAD) // [R21]
    else $error("load without enable");
  a_index_off: assert property (@(posedge CORE_CLK) disable iff (RST)
    !decoder_reg[0] |=> !INDEX_RESET) // [R18]
    else $error("index reset while disabled");
  a_flag_on_timeout: assert property (@(posedge CORE_CLK) disable iff (RST)
    dd_en && wdg_cnt_a == wdg_period && !ENC_A_EDGE |=> DISCONNECT_FLAG) // [R5]
    else $error("timeout lost");
  a_no_dd_no_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
    !dd_en && !DISCONNECT_FLAG |=> !DISCONNECT_FLAG) // [R6]
    else $error("flag without detection");
  a_repsel_gate: assert property (@(posedge CORE_CLK) disable iff (RST)
    !repsel |=> !REPEAT_UPDATE) // [R8]
    else $error("second repeat used unselected");
  a_dt_decode: assert property (@(posedge CORE_CLK) disable iff (RST)
    !dt_locked && deadtime_reg[7:5] == 3'b111 |=>
      DEADTIME_RISE_TICKS == {6'h00, 1'b1, $past(deadtime_reg[4:0])} * 12'd16) // [R11]
    else $error("dead-time decode wrong");
  a_sync_read_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
    PREADY && !PWRITE && PADDR == ADDR_PRELOAD_CTRL |-> PRDATA[2] == 1'b0) // [R19]
    else $error("soft sync reads one");
endmodule // tdxext_top

/* testbench/tb.sv */
`timescale 1ns/10ps
module tb;
  import tdxext_pkg::*;
  // ****************************************
  // Bench signals
  // ****************************************
  logic clk, rst, psel, penable, pwrite, counter_enable, upd, tick, cdown, hsync, filt, step, idx;
  logic [7:0] paddr, cmp;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] protection_level, center_align_mode;
  logic [2:0] dmode, pin;
  logic pready, pslverr, brk_out, rep_upd, idx_rst, idx_pls, pre_ld, pre_up, dflag, dirq;
  logic enc_a, enc_b, enc_i, a_edge, b_edge;
  logic [7:0] dt_r, dt_f;
  logic [11:0] tk_r, tk_f;
  logic [15:0] pre_val;
  logic [7:0] dt_code [4] = '{8'h25, 8'ha3, 8'hc5, 8'hff};
  logic [11:0] dt_tick [4] = '{12'd37, 12'd198, 12'd296, 12'd1008};
  int errors = 0;
  int num_checks = 0;
  int n;

  tdxext_top i_dut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PROTECTION_LEVEL(protection_level), .COUNTER_ENABLE(counter_enable), .UPDATE_EVENT(upd),
    .COUNT_TICK(tick), .CENTER_ALIGN_MODE(center_align_mode), .COUNT_DOWN(cdown), .DECODER_MODE(dmode),
    .HW_SYNC(hsync), .BRK_B_COMPARATOR(cmp), .BRK_B_FILTER_UNIT(filt), .BRK_B_PIN(pin),
    .ENC_A(enc_a), .ENC_B(enc_b), .ENC_INDEX(enc_i), .ENC_A_EDGE(a_edge),
    .ENC_B_EDGE(b_edge), .BRK_B_OUT(brk_out), .DEADTIME_RISE(dt_r), .DEADTIME_FALL(dt_f),
    .DEADTIME_RISE_TICKS(tk_r), .DEADTIME_FALL_TICKS(tk_f), .REPEAT_UPDATE(rep_upd),
    .INDEX_RESET(idx_rst), .INDEX_PULSE(idx_pls), .PRELOAD_LOAD(pre_ld),
    .PRELOAD_VALUE_OUT(pre_val), .PRELOAD_DIR_UP(pre_up), .DISCONNECT_FLAG(dflag),
    .DISCONNECT_IRQ(dirq));

  tdxext_enc_model i_enc (.clk(clk), .rst(rst), .step(step), .idx_req(idx), .enc_a(enc_a),
    .enc_b(enc_b), .enc_index(enc_i), .a_edge(a_edge), .b_edge(b_edge));

  // 40 MHz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task end_sim;
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      $display("[ERR] %0t bus wait ran out", $time);
      end_sim;
    end
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Counts edges at which a design output is high
  task automatic count(ref logic s, input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(posedge clk);
      if (s === 1'b1) c++;
    end
  endtask

  task enc_step(input int k);
    repeat (k) begin
      step <= 1'b1;
      @(posedge clk);
      step <= 1'b0;
      @(posedge clk);
    end
  endtask

  // Two index pulses, total of counter resets checked against exp_n
  task idx_run(input int exp_n);
    int c, t, k;
    t = 0;
    for (k = 0; k < 2; k++) begin
      idx <= 1'b1;
      @(posedge clk);
      idx <= 1'b0;
      count(idx_rst, 6, c);
      t += c;
    end
    chk(t, exp_n);
  endtask

  function automatic int gbit(int i);
    if (i < 3) return i;
    if (i == 3) return 8;
    if (i < 11) return i + 5;
    return 7;
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    logic [7:0] a;
    for (a = 8'h90; a <= 8'hb0; a += 8'h4) begin
      rd_chk(a, (a == ADDR_WDG_PERIOD) ? RST_WDG_PERIOD : RST_ZERO);
    end
    rd_chk(8'h80, RST_ZERO);
    chk({31'h0, pslverr}, 32'h0);
    apb(1'b1, ADDR_REPEAT_SECOND, 32'hdeadbeef);
    rd_chk(ADDR_REPEAT_SECOND, 32'hdeadbeef);
  endtask

  // One gate at a time: own source passes, all others are blocked
  task t_break;
    int i;
    for (i = 0; i < 12; i++) begin
      apb(1'b1, ADDR_BRK_SRC, 32'h1 << gbit(i));
      {cmp, filt, pin} <= 12'h1 << i;
      repeat (3) @(posedge clk);
      chk({31'h0, brk_out}, 32'h1);
      {cmp, filt, pin} <= ~(12'h1 << i);
      repeat (3) @(posedge clk);
      chk({31'h0, brk_out}, 32'h0);
    end
    {cmp, filt, pin} <= 12'h0;
    apb(1'b1, ADDR_BRK_SRC, 32'hffffffff);
    rd_chk(ADDR_BRK_SRC, MASK_BRK_SRC);
    protection_level <= 2'h1;
    apb(1'b1, ADDR_BRK_SRC, 32'h0);
    rd_chk(ADDR_BRK_SRC, MASK_BRK_SRC);
    protection_level <= 2'h0;
  endtask

  task t_dead;
    int i;
    for (i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_DEADTIME_SECOND, {24'h0, dt_code[i]});
      repeat (3) @(posedge clk);
      chk({20'h0, tk_r}, {20'h0, dt_tick[i]});
      chk({20'h0, tk_f}, {20'h0, dt_tick[i]});
      chk({16'h0, dt_r, dt_f}, {16'h0, dt_code[i], dt_code[i]});
    end
    apb(1'b1, ADDR_DEADTIME_SECOND, 32'hff010025);
    rd_chk(ADDR_DEADTIME_SECOND, 32'h00010025);
    chk({20'h0, tk_f}, 32'd1008);
    protection_level <= 2'h2;
    apb(1'b1, ADDR_DEADTIME_SECOND, 32'h10);
    rd_chk(ADDR_DEADTIME_SECOND, 32'h00010025);
    protection_level <= 2'h0;
    counter_enable <= 1'b1;
    apb(1'b1, ADDR_DEADTIME_SECOND, 32'h20025);
    apb(1'b1, ADDR_DEADTIME_SECOND, 32'h200ff);
    repeat (3) @(posedge clk);
    chk({20'h0, tk_r}, 32'd37);
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
    repeat (3) @(posedge clk);
    chk({20'h0, tk_r}, 32'd1008);
    counter_enable <= 1'b0;
  endtask

  task sync_run(input logic [31:0] ctl, input logic hw, input int exp_n, input logic up);
    int c;
    apb(1'b1, ADDR_PRELOAD_CTRL, ctl);
    if (hw) begin
      hsync <= 1'b1;
      @(posedge clk);
      hsync <= 1'b0;
    end
    count(pre_ld, 6, c);
    chk(c, exp_n);
    if (exp_n > 0) chk({31'h0, pre_up}, {31'h0, up});
  endtask

  task t_sync;
    center_align_mode <= 2'h1;
    apb(1'b1, ADDR_PRELOAD_VALUE, 32'hffffbeef);
    rd_chk(ADDR_PRELOAD_VALUE, 32'h0000beef);
    sync_run(32'h7, 1'b0, 1, 1'b1);
    chk({16'h0, pre_val}, 32'hbeef);
    rd_chk(ADDR_PRELOAD_CTRL, 32'h3);
    sync_run(32'h1, 1'b1, 1, 1'b0);
    center_align_mode <= 2'h0;
    sync_run(32'h1, 1'b1, 1, 1'b1);
    sync_run(32'h4, 1'b0, 0, 1'b0);
  endtask

  task t_index;
    int c;
    dmode <= DECODER_MODE_AB_MAX;
    enc_step(2);
    apb(1'b1, ADDR_DECODER_INDEX, 32'hc0);
    idx_run(0);
    apb(1'b1, ADDR_DECODER_INDEX, 32'hc1);
    idx_run(2);
    apb(1'b1, ADDR_DECODER_INDEX, 32'hc3);
    rd_chk(ADDR_DECODER_INDEX, 32'hc1);
    enc_step(1);
    idx_run(0);
    enc_step(3);
    apb(1'b1, ADDR_DECODER_INDEX, 32'hc0);
    apb(1'b1, ADDR_DECODER_INDEX, 32'he1);
    idx_run(1);
    apb(1'b1, ADDR_DECODER_INDEX, 32'hc2);
    apb(1'b1, ADDR_DECODER_INDEX, 32'hc3);
    cdown <= 1'b1;
    idx_run(0);
    cdown <= 1'b0;
    idx_run(2);
    apb(1'b1, ADDR_DECODER_INDEX, 32'hc0);
    apb(1'b1, ADDR_DECODER_INDEX, 32'h000500c1);
    idx <= 1'b1;
    @(posedge clk);
    idx <= 1'b0;
    count(idx_pls, 20, c);
    chk(c, 5);
    apb(1'b1, ADDR_DECODER_INDEX, 32'h010200c1);
    idx <= 1'b1;
    @(posedge clk);
    idx <= 1'b0;
    count(idx_pls, 20, c);
    chk(c, 4);
    dmode <= DECODER_MODE_CLK_MAX;
    idx_run(2);
    enc_step(2);
    idx_run(0);
  endtask

  // Second repeat value 2: one update per three ticks, only when selected
  task t_repeat;
    int c, k;
    apb(1'b1, ADDR_REPEAT_SECOND, 32'h2);
    for (k = 0; k < 2; k++) begin
      apb(1'b1, ADDR_CONFIG, 32'(k));
      tick <= 1'b1;
      count(rep_upd, 6, c);
      tick <= 1'b0;
      chk(c, 2 * k);
    end
  endtask

  task t_wdg;
    int c;
    apb(1'b1, ADDR_WDG_PERIOD, 32'h10);
    count(dflag, 40, c);
    chk(c, 0);
    apb(1'b1, ADDR_CONFIG, 32'h6);
    repeat (60) @(posedge clk);
    chk({30'h0, dflag, dirq}, 32'h3);
    apb(1'b1, ADDR_CONFIG, 32'h2);
    repeat (3) @(posedge clk);
    chk({31'h0, dirq}, 32'h0);
    apb(1'b1, ADDR_CONFIG, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, dflag}, 32'h0);
  endtask

  // Main sequence; every input defined at time zero
  initial begin
    {rst, psel, penable, pwrite, counter_enable, upd, tick, cdown, hsync, filt, step, idx} = 12'h800;
    {paddr, cmp, pwdata, protection_level, center_align_mode, dmode, pin} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_repeat;
    t_break;
    t_dead;
    t_sync;
    t_index;
    t_wdg;
    end_sim;
  end
endmodule // tb

/* testbench/tdxext_enc_model.sv */
`timescale 1ns/10ps
// ****************************************
// Quadrature encoder model
// ****************************************
module tdxext_enc_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Commands from the bench
  input wire logic step,
  input wire logic idx_req,
  // Encoder lines
  output logic enc_a,
  output logic enc_b,
  output logic enc_index,
  output logic a_edge,
  output logic b_edge
);
  logic [1:0] ph;

  // Gray walk 00-01-11-10: one line moves per step, so no glitch states
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph <= 2'h0;
      a_edge <= 1'b0;
      b_edge <= 1'b0;
      enc_index <= 1'b0;
    end else begin
      if (step) begin
        ph <= {ph[0], ~ph[1]};
      end
      a_edge <= step & (ph[1] ^ ph[0]);
      b_edge <= step & ~(ph[1] ^ ph[0]);
      enc_index <= idx_req;
    end
  end

  assign enc_a = ph[1];
  assign enc_b = ph[0];
endmodule // tdxext_enc_model
